//--- hdl/ssf_pkg.sv
// Package: register map, field positions and modes of the serial status flags
package ssf_pkg;
    // Register byte offsets
    localparam logic [7:0] SSF_STATUS_OFFS = 8'h00;
    localparam logic [7:0] SSF_CTRL_OFFS = 8'h04;
    localparam logic [7:0] SSF_MODE_OFFS = 8'h08;
    localparam logic [7:0] SSF_STATB_OFFS = 8'h0c;
    // Status register A field positions
    localparam int SSF_RXST_LO = 26;
    localparam int SSF_RXST_W = 6;
    localparam int SSF_RX_READY_BIT = 11;
    localparam int SSF_RX_CLOSED_BIT = 9;
    localparam int SSF_RX_FULL_BIT = 8;
    localparam int SSF_DCD_BIT = 7;
    localparam int SSF_DSR_BIT = 5;
    localparam int SSF_CTS_BIT = 4;
    localparam int SSF_TX_READY_BIT = 3;
    localparam int SSF_TX_HALF_BIT = 2;
    localparam int SSF_TX_CLOSED_BIT = 1;
    localparam int SSF_TX_EMPTY_BIT = 0;
    // Status register B field (HDLC receive status)
    localparam int SSF_HST_LO = 16;
    localparam int SSF_HST_W = 10;
    // Mode register field positions
    localparam int SSF_MODE_LO = 0;
    localparam int SSF_RXDMA_BIT = 2;
    localparam int SSF_TXDMA_BIT = 3;
    // Transmit FIFO room threshold in bytes for half-empty
    localparam int SSF_TX_HALF_ROOM = 16;
    // Reset values
    localparam logic [31:0] SSF_CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] SSF_SLVERR_NONE = 32'h0000_0000;
    // Sticky bits cleared by write-one
    localparam logic [31:0] SSF_W1C_MASK = 32'h0000_02b2;
    // Channel protocol modes
    typedef enum logic [1:0] {
        SSF_MODE_UART,
        SSF_MODE_SPI,
        SSF_MODE_HDLC
    } ssf_mode_e;
endpackage

//--- hdl/ssf_serial_status_flags.sv
// Status and pending-flag logic of a serial channel, with APB registers
//
// Our own choices: the address map and the APB slave port.
`timescale 1ns/10ps
module ssf_serial_status_flags
    import ssf_pkg::*;
#(
    parameter int TX_DEPTH = 32,
    parameter int CW = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic rx_close_evt,
    input wire logic [SSF_RXST_W-1:0] rx_close_status,
    input wire logic [SSF_HST_W-1:0] rx_hdlc_status,
    input wire logic rx_fifo_nonempty,
    input wire logic rx_fifo_full,
    input wire logic [CW-1:0] tx_fifo_room,
    input wire logic tx_shift_idle,
    input wire logic carrier_detect_pin,
    input wire logic set_ready_pin,
    input wire logic clear_to_send_pin,
    output logic [SSF_RXST_W-1:0] rx_desc_status,
    output logic rx_desc_write,
    output logic rx_data_ready_flag,
    output logic tx_space_ready_flag,
    output logic irq
);

    logic [31:0] ctrl;
    logic [31:0] mode_reg;
    logic rx_buffer_closed_flag;
    logic tx_buffer_closed_flag;
    logic carrier_detect_change_flag;
    logic set_ready_change_flag;
    logic clear_to_send_change_flag;
    logic [SSF_RXST_W-1:0] rx_status_hold;
    logic [SSF_HST_W-1:0] hdlc_status_hold;
    logic [2:0] pin_s1;
    logic [2:0] pin_s2;
    logic [2:0] pin_s3;
    logic tx_was_busy;
    logic wr_acc;
    logic rd_acc;
    logic [7:0] wr_addr;
    logic [31:0] wdat;
    logic [31:0] next_status;
    logic [31:0] next_prdata;
    logic dma_uart_rx;
    logic dma_uart_tx;
    logic ack_rx_closed;
    logic ack_tx_closed;
    logic rx_close_set;
    logic tx_close_set;
    logic [2:0] pin_change;
    logic tx_fifo_empty_flag;
    logic tx_fifo_half_empty_flag;
    logic next_rx_rdy;
    logic next_tx_rdy;
    logic next_irq;
    logic [31:0] pend;

    // Register map, one aligned word each:
    //   0x00 status A: sticky change and closed flags, live levels
    //   0x04 control: interrupt enables, same bit layout as status A
    //   0x08 mode: protocol in bits 1:0, receive DMA bit 2,
    //        transmit DMA bit 3
    //   0x0c status B: HDLC receive status in bits 25:16
    // Sharing the layout makes the interrupt a plain AND of the
    // pending bits and the enables.

    // No wait states, so the write strobe is the access phase alone
    // Single-cycle APB: every access completes in its access phase
    assign wr_acc = psel && penable && pwrite;
    assign rd_acc = psel && penable && !pwrite;
    assign wr_addr = paddr;
    // Byte strobes gate each lane of the written word
    assign wdat = pwdata & {{8{pstrb[3]}}, {8{pstrb[2]}},
                            {8{pstrb[1]}}, {8{pstrb[0]}}};

    // Mode decode: DMA self-acknowledge exists only outside HDLC
    // Both DMA bits are ignored in HDLC, where software always acks
    assign dma_uart_rx = mode_reg[SSF_RXDMA_BIT]
        && (mode_reg[SSF_MODE_LO +: 2] != 2'(SSF_MODE_HDLC));
    assign dma_uart_tx = mode_reg[SSF_TXDMA_BIT]
        && (mode_reg[SSF_MODE_LO +: 2] != 2'(SSF_MODE_HDLC));

    // Write-one acknowledges; a zero leaves the flag alone
    // Only the status A offset carries write-one bits
    assign ack_rx_closed = wr_acc && (wr_addr == SSF_STATUS_OFFS)
        && wdat[SSF_RX_CLOSED_BIT];
    assign ack_tx_closed = wr_acc && (wr_addr == SSF_STATUS_OFFS)
        && wdat[SSF_TX_CLOSED_BIT];

    assign rx_close_set = rx_close_evt;
    // Transmit closes on the busy-to-idle edge: shifter idle and FIFO empty after a busy cycle
    // Room equal to the depth means the FIFO holds nothing
    assign tx_fifo_empty_flag = (32'(tx_fifo_room) == TX_DEPTH);
    assign tx_close_set = tx_was_busy && tx_shift_idle
        && tx_fifo_empty_flag;
    assign tx_fifo_half_empty_flag =
        (32'(tx_fifo_room) >= SSF_TX_HALF_ROOM);

    // Modem inputs pass two flops before edge detection
    // Pins are asynchronous to pclk; the third stage only serves the
    // edge detector and never feeds other logic.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= 3'h0;
            pin_s2 <= 3'h0;
            pin_s3 <= 3'h0;
        end else begin
            pin_s1 <= {carrier_detect_pin, set_ready_pin,
                       clear_to_send_pin};
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end
    // First sample after reset may flag a change; software acks it
    // A glitch shorter than a clock may be missed entirely; modems
    // hold their status lines far longer than that.
    assign pin_change = pin_s2 ^ pin_s3;

    // Control and mode registers written by software
    // Only mode bits 3:0 act; upper bits read back as written so
    // software may keep its own tags there.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= SSF_CTRL_RST;
            mode_reg <= SSF_CTRL_RST;
        end else if (wr_acc) begin
            if (wr_addr == SSF_CTRL_OFFS) begin
                ctrl <= wdat;
            end
            if (wr_addr == SSF_MODE_OFFS) begin
                mode_reg <= wdat;
            end
        end
    end

    // Receive closed flag: set beats clear; DMA acks in hardware
    // With DMA on outside HDLC the flag is held clear every cycle,
    // so a close never reaches software or the interrupt.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buffer_closed_flag <= 1'b0;
        end else if (rx_close_set && !dma_uart_rx) begin
            rx_buffer_closed_flag <= 1'b1;
        end else if (ack_rx_closed || dma_uart_rx) begin
            rx_buffer_closed_flag <= 1'b0;
        end
    end

    // Closing status captured so it stays valid until acknowledged
    // Captured on every close; in DMA mode the held receive status is never
    // shown because the closed flag stays clear.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_status_hold <= '0;
            hdlc_status_hold <= '0;
        end else if (rx_close_set) begin
            rx_status_hold <= rx_close_status;
            hdlc_status_hold <= rx_hdlc_status;
        end
    end

    // DMA path writes the status into the buffer descriptor
    // Write pulse lasts one cycle, one pulse per closed buffer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_desc_status <= '0;
            rx_desc_write <= 1'b0;
        end else begin
            rx_desc_write <= rx_close_set && dma_uart_rx;
            if (rx_close_set && dma_uart_rx) begin
                rx_desc_status <= rx_close_status;
            end
        end
    end

    // Transmit closed flag, self-acknowledged in UART/SPI DMA
    // Busy means shifter active or FIFO holding data; closing needs
    // a busy-to-idle transition so an idle channel after reset
    // never reports a closed buffer.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_buffer_closed_flag <= 1'b0;
            tx_was_busy <= 1'b0;
        end else begin
            tx_was_busy <= !tx_shift_idle || !tx_fifo_empty_flag;
            if (tx_close_set && !dma_uart_tx) begin
                tx_buffer_closed_flag <= 1'b1;
            end else if (ack_tx_closed || dma_uart_tx) begin
                tx_buffer_closed_flag <= 1'b0;
            end
        end
    end

    // Modem change flags: sticky, event wins over write-one
    // Acks come through ack_sticky, which gates on the status
    // address and the byte strobes.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_detect_change_flag <= 1'b0;
            set_ready_change_flag <= 1'b0;
            clear_to_send_change_flag <= 1'b0;
        end else begin
            if (pin_change[2]) begin
                carrier_detect_change_flag <= 1'b1;
            end else if (ack_sticky(SSF_DCD_BIT)) begin
                carrier_detect_change_flag <= 1'b0;
            end
            if (pin_change[1]) begin
                set_ready_change_flag <= 1'b1;
            end else if (ack_sticky(SSF_DSR_BIT)) begin
                set_ready_change_flag <= 1'b0;
            end
            if (pin_change[0]) begin
                clear_to_send_change_flag <= 1'b1;
            end else if (ack_sticky(SSF_CTS_BIT)) begin
                clear_to_send_change_flag <= 1'b0;
            end
        end
    end

    // Write-one acknowledge for one status bit position
    function automatic logic ack_sticky(input int b);
        ack_sticky = wr_acc && (wr_addr == SSF_STATUS_OFFS) && wdat[b];
    endfunction

    // Ready flags gated by closed-buffer interlocks
    // The close event itself also blocks ready, so ready drops at
    // the edge the closed flag rises, with no one-cycle gap.
    // Transmit: room above half always accepts a write; below it,
    // any nonzero room does.
    always_comb begin
        next_rx_rdy = rx_fifo_nonempty && !rx_buffer_closed_flag
            && !rx_close_set;
        next_tx_rdy = !tx_fifo_half_empty_flag ? (32'(tx_fifo_room) != 0)
            : 1'b1;
        next_tx_rdy = next_tx_rdy && !tx_buffer_closed_flag
            && !tx_close_set;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_data_ready_flag <= 1'b0;
            tx_space_ready_flag <= 1'b0;
        end else begin
            rx_data_ready_flag <= next_rx_rdy;
            tx_space_ready_flag <= next_tx_rdy;
        end
    end

    // Assembled status word; live bits never stored from writes
    // Receive status shows only while the closed flag is set outside
    // HDLC; otherwise those bits read zero.
    always_comb begin
        next_status = '0;
        if (rx_buffer_closed_flag
            && mode_reg[SSF_MODE_LO +: 2] != 2'(SSF_MODE_HDLC)) begin
            next_status[SSF_RXST_LO +: SSF_RXST_W] = rx_status_hold;
        end
        next_status[SSF_RX_READY_BIT] = rx_data_ready_flag;
        next_status[SSF_RX_CLOSED_BIT] = rx_buffer_closed_flag;
        next_status[SSF_RX_FULL_BIT] = rx_fifo_full;
        next_status[SSF_DCD_BIT] = carrier_detect_change_flag;
        next_status[SSF_DSR_BIT] = set_ready_change_flag;
        next_status[SSF_CTS_BIT] = clear_to_send_change_flag;
        next_status[SSF_TX_READY_BIT] = tx_space_ready_flag;
        next_status[SSF_TX_HALF_BIT] = tx_fifo_half_empty_flag;
        next_status[SSF_TX_CLOSED_BIT] = tx_buffer_closed_flag;
        next_status[SSF_TX_EMPTY_BIT] = tx_fifo_empty_flag;
    end

    // Read mux; unmapped addresses read zero without error
    // Status B holds the HDLC status of the last close
    always_comb begin
        unique case (paddr)
            SSF_STATUS_OFFS: next_prdata = next_status;
            SSF_CTRL_OFFS: next_prdata = ctrl;
            SSF_MODE_OFFS: next_prdata = mode_reg;
            SSF_STATB_OFFS: next_prdata =
                32'(hdlc_status_hold) << SSF_HST_LO;
            default: next_prdata = '0;
        endcase
    end

    // Registered read data, presented in the access phase
    // Data is latched in the setup phase so it stands for the whole
    // access; pready rises for exactly the access cycle, no waits.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            prdata <= (psel && !penable && !pwrite) ? next_prdata : prdata;
            pready <= psel && !penable;
            pslverr <= SSF_SLVERR_NONE[0];
        end
    end

    // Pending set: each closed/change flag plus live ready levels
    // Ready and half-empty are levels: their interrupt stays high
    // while the condition holds, unlike the sticky change flags.
    assign pend = next_status & SSF_W1C_MASK
        | (32'(tx_space_ready_flag) << SSF_TX_READY_BIT)
        | (32'(tx_fifo_half_empty_flag) << SSF_TX_HALF_BIT)
        | (32'(rx_data_ready_flag) << SSF_RX_READY_BIT);
    // Registered so irq comes straight from a flop, one cycle
    // behind the pending bits
    assign next_irq = |(pend & ctrl);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

endmodule

//--- tb/ssf_modem_model.sv
// Modem side model: drives the three EIA status pins
`timescale 1ns/10ps
module ssf_modem_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [2:0] flip,
    output logic carrier_detect_pin,
    output logic set_ready_pin,
    output logic clear_to_send_pin
);
    // Pins move just after an edge, as a real modem would, never mid-check
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            carrier_detect_pin <= 1'b0;
            set_ready_pin <= 1'b0;
            clear_to_send_pin <= 1'b0;
        end else begin
            carrier_detect_pin <= carrier_detect_pin ^ flip[2];
            set_ready_pin <= set_ready_pin ^ flip[1];
            clear_to_send_pin <= clear_to_send_pin ^ flip[0];
        end
    end
endmodule

//--- tb/ssf_flags_asserts.sv
// Checker: port-level properties of the serial status flags
`timescale 1ns/10ps
module ssf_flags_asserts
    import ssf_pkg::*;
#(
    parameter int TX_DEPTH = 32,
    parameter int CW = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic rx_close_evt,
    input wire logic [SSF_RXST_W-1:0] rx_close_status,
    input wire logic rx_fifo_nonempty,
    input wire logic rx_fifo_full,
    input wire logic [CW-1:0] tx_fifo_room,
    input wire logic [SSF_RXST_W-1:0] rx_desc_status,
    input wire logic rx_desc_write,
    input wire logic rx_data_ready_flag,
    input wire logic tx_space_ready_flag,
    input wire logic irq
);
    logic [3:0] mode_m;
    logic [31:0] ctrl_m;
    logic closed_m;
    logic wr;
    logic dma;
    // Only full-word writes are shadowed; partial writes go unmodelled
    assign wr = psel && penable && pwrite && pstrb == 4'hf;
    assign dma = mode_m[2] && mode_m[1:0] != 2'h2;
    // Shadow of mode, enables and receive closed flag; set wins
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_m <= 4'h0;
            ctrl_m <= 32'h0;
            closed_m <= 1'b0;
        end else begin
            if (wr && paddr == SSF_MODE_OFFS) mode_m <= pwdata[3:0];
            if (wr && paddr == SSF_CTRL_OFFS) ctrl_m <= pwdata;
            if (rx_close_evt && !dma) closed_m <= 1'b1;
            else if (wr && paddr == 8'h00 && pwdata[9]) closed_m <= 1'b0;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_rx_interlock: assert property (closed_m |-> !rx_data_ready_flag)
        else $error("receive ready while closed");
    a_desc_copy: assert property (rx_close_evt && dma |=> rx_desc_write
        && rx_desc_status == $past(rx_close_status)) else $error("desc");
    a_desc_cause: assert property (!$past(rx_close_evt) |-> !rx_desc_write)
        else $error("descriptor write without close");
    a_pready_access: assert property (psel |-> pready == penable)
        else $error("pready out of access phase");
    a_tx_room: assert property ($past(tx_fifo_room) == '0
        |-> !tx_space_ready_flag) else $error("tx ready with no room");
    a_rx_data: assert property (!$past(rx_fifo_nonempty)
        |-> !rx_data_ready_flag) else $error("rx ready with no data");
    a_irq_closed: assert property (closed_m && ctrl_m[9] |=> irq)
        else $error("closed interrupt missing");
    a_irq_masked: assert property (ctrl_m == 32'h0 && $past(ctrl_m) == 32'h0
        |-> !irq) else $error("interrupt with all enables off");
    a_status_read: assert property (psel && !penable && !pwrite
        && paddr == 8'h00 |=> prdata[8] == $past(rx_fifo_full)
        && prdata[9] == $past(closed_m)) else $error("status read");
endmodule
bind ssf_serial_status_flags ssf_flags_asserts #(.TX_DEPTH(TX_DEPTH), .CW(CW))
    u_ssf_flags_asserts (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .rx_close_evt, .rx_close_status,
    .rx_fifo_nonempty, .rx_fifo_full, .tx_fifo_room, .rx_desc_status,
    .rx_desc_write, .rx_data_ready_flag, .tx_space_ready_flag, .irq);

//--- tb/tb_serial_status_flags.sv
// Testbench: bus, receive, modem-pin and transmit flag scenarios
`timescale 1ns/10ps
module tb_serial_status_flags
    import ssf_pkg::*;
;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, rx_close_evt = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata;
    logic [3:0] pstrb = 4'hf;
    logic [SSF_RXST_W-1:0] rx_close_status = '0, rx_desc_status;
    logic [SSF_HST_W-1:0] rx_hdlc_status = '0;
    logic rx_fifo_nonempty = 1'b0, rx_fifo_full = 1'b0, tx_shift_idle = 1'b1;
    logic [5:0] tx_fifo_room = 6'h20;
    logic carrier_detect_pin, set_ready_pin, clear_to_send_pin, irq;
    logic rx_desc_write, rx_data_ready_flag, tx_space_ready_flag;
    logic [2:0] flip = 3'h0;
    logic [31:0] exp_q[$], msk_q[$];
    int err_count = 0, check_count = 0, cyc = 0;
    int rooms[5] = '{16, 15, 1, 0, 32};
    always #2 pclk = ~pclk;
    ssf_serial_status_flags u_ssf_serial_status_flags (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .rx_close_evt, .rx_close_status, .rx_hdlc_status,
        .rx_fifo_nonempty, .rx_fifo_full, .tx_fifo_room, .tx_shift_idle,
        .carrier_detect_pin, .set_ready_pin, .clear_to_send_pin,
        .rx_desc_status, .rx_desc_write, .rx_data_ready_flag,
        .tx_space_ready_flag, .irq);
    ssf_modem_model u_ssf_modem_model (.pclk, .presetn, .flip,
        .carrier_detect_pin, .set_ready_pin, .clear_to_send_pin);
    task automatic close_out();
        if (err_count == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic cmp(string nm, logic [31:0] e, logic [31:0] g);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic tick(int n);
        repeat (n) @(posedge pclk);
    endtask
    // Idle edge first, so a release and the next setup never collide
    task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, logic [31:0] e, logic [31:0] m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        apb(1'b0, a, 32'h0);
    endtask
    task automatic close_pulse();
        rx_close_status <= 6'($urandom);
        rx_hdlc_status <= 10'($urandom);
        rx_close_evt <= 1'b1;
        @(posedge pclk);
        rx_close_evt <= 1'b0;
        tick(2);
    endtask
    // Read results are checked at the edge that completes the access
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size()) begin
            cmp("read", exp_q[0] & msk_q[0], prdata & msk_q[0]);
            cmp("pslverr", 32'h0, 32'(pslverr));
            void'(exp_q.pop_front());
            void'(msk_q.pop_front());
        end
    end
    // Hang guard, well above the length of the sequence
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 4000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        int b;
        void'($urandom(32'heb7e));
        tick(16);
        presetn <= 1'b1;
        rx_fifo_nonempty <= 1'b1;
        rx_fifo_full <= 1'($urandom);
        apb(1'b1, SSF_CTRL_OFFS, 32'h200);
        tick(2);
        cmp("rx ready", 1, rx_data_ready_flag);
        // Closed flag: status capture, interlock, zero write kept
        close_pulse();
        cmp("rx ready", 0, rx_data_ready_flag);
        cmp("irq", 1, irq);
        apb(1'b1, 8'h00, 32'hfffffdff);
        rd(8'h00, {rx_close_status, 26'h200} | {23'h0, rx_fifo_full, 8'h0},
            32'hfc000b00);
        apb(1'b1, 8'h00, 32'h200);
        tick(2);
        cmp("rx ready", 1, rx_data_ready_flag);
        cmp("irq", 0, irq);
        // HDLC with receive DMA still needs software to acknowledge
        apb(1'b1, SSF_MODE_OFFS, 32'h6);
        close_pulse();
        rd(SSF_STATB_OFFS, {6'h0, rx_hdlc_status, 16'h0}, 32'h03ff0000);
        rd(8'h00, 32'h200, 32'h200);
        apb(1'b1, 8'h00, 32'h200);
        // UART and SPI receive DMA acknowledge in hardware
        for (int m = 4; m < 6; m++) begin
            apb(1'b1, SSF_MODE_OFFS, 32'(m));
            close_pulse();
            rd(8'h00, 32'h0, 32'h200);
            cmp("rx ready", 1, rx_data_ready_flag);
        end
        apb(1'b1, SSF_MODE_OFFS, 32'h0);
        // Each modem pin change: sticky, interrupts, cleared by one
        for (int i = 0; i < 3; i++) begin
            b = (i == 0) ? 7 : (i == 1) ? 5 : 4;
            apb(1'b1, SSF_CTRL_OFFS, 32'h1 << b);
            flip <= 3'h4 >> i;
            @(posedge pclk);
            flip <= 3'h0;
            tick(6);
            cmp("irq", 1, irq);
            rd(8'h00, 32'h1 << b, 32'hb0);
            apb(1'b1, 8'h00, 32'h1 << b);
            tick(2);
            cmp("irq", 0, irq);
        end
        apb(1'b1, SSF_CTRL_OFFS, 32'h0);
        // Room boundaries, then drained FIFO closes the transmit side
        foreach (rooms[k]) begin
            tx_fifo_room <= 6'(rooms[k]);
            tick(4);
            b = rooms[k];
            rd(8'h00, {28'h0, b != 0 && b != 32, b >= 16, b == 32, b == 32},
                32'hf);
        end
        cmp("tx ready", 0, tx_space_ready_flag);
        apb(1'b1, 8'h00, 32'h2);
        tick(3);
        cmp("tx ready", 1, tx_space_ready_flag);
        rd(8'h10, 32'h0, 32'hffffffff);
        tick(2);
        close_out();
    end
endmodule
